// file: core/smac_pkg.sv
/*
  Constants and types shared by both ends of the surface address calculator.
  Assumes a single core clock and nothing else from its surroundings.
*/
package smac_pkg;

  localparam int unsigned DIM_W      = 14;
  localparam int unsigned LOD_W      = 4;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned OFS_W      = 32;
  localparam int unsigned PIPE_LAT   = 3;
  localparam logic [31:0] MAX_BYTES  = 32'h8000_0000;
  localparam logic [11:0] MAX_STRUCT = 12'h800;
  localparam logic [1:0]  DW_ALIGN   = 2'h0;
  localparam logic [3:0]  TILE_ALIGN = 4'h0;
  localparam logic [1:0]  RST_ZERO2  = 2'h0;

  typedef enum logic [2:0]
  {
    SMAC_SURF_BUFFER     = 3'h0,
    SMAC_SURF_STRUCTURED = 3'h1,
    SMAC_SURF_1D         = 3'h2,
    SMAC_SURF_2D         = 3'h3,
    SMAC_SURF_DEPTH      = 3'h4,
    SMAC_SURF_STENCIL    = 3'h5
  } smac_surf_e;

  typedef enum logic [2:0]
  {
    SMAC_FMT_PLAIN    = 3'h0,
    SMAC_FMT_D16      = 3'h1,
    SMAC_FMT_BC_SMALL = 3'h2,
    SMAC_FMT_BC       = 3'h3,
    SMAC_FMT_EIGHT_W  = 3'h4,
    SMAC_FMT_FOUR_BIT = 3'h5,
    SMAC_FMT_YUV422   = 3'h6,
    SMAC_FMT_RAW      = 3'h7
  } smac_fmt_e;

  typedef enum logic [1:0]
  {
    SMAC_MIP_STEP_RIGHT = 2'h0,
    SMAC_MIP_STEP_DOWN  = 2'h1,
    SMAC_MIP_OLD        = 2'h2
  } smac_layout_e;

  typedef struct packed
  {
    smac_surf_e             surf;
    smac_fmt_e              fmt;
    smac_layout_e           layout;
    logic                   tiled;
    logic [4:0]             samples;
    logic                   ms_depth_style;
    logic [4:0]             bpp;
    logic [3:0]             align_w;
    logic [3:0]             align_h;
    logic [DIM_W-1:0]       width;
    logic [DIM_W-1:0]       height;
    logic [LOD_W-1:0]       lod;
    logic [17:0]            pitch_dw;
    logic [DIM_W+7:0]       slice_pitch;
    logic [11:0]            slice;
    logic [DIM_W-1:0]       u;
    logic [ADDR_W-1:0]      base;
  } smac_req_s;

  typedef struct packed
  {
    logic [DIM_W+3:0]       lod_w;
    logic [DIM_W+3:0]       lod_h;
    logic [DIM_W+3:0]       ul_x;
    logic [DIM_W+3:0]       ul_y;
    logic [ADDR_W-1:0]      addr;
    logic                   err;
  } smac_rsp_s;

endpackage

// file: core/smac_if.sv
/*
  Request and answer link between a pipeline requester and the calculator.
  Assumes both ends share core_clk; the bench joins the two ends here.
*/
`timescale 1ns/1ps
interface smac_if;
  logic                  req_valid;
  smac_pkg::smac_req_s   req;
  logic                  rsp_valid;
  smac_pkg::smac_rsp_s   rsp;

  modport calc
  (
    input  req_valid,
    input  req,
    output rsp_valid,
    output rsp
  );

  modport requester
  (
    output req_valid,
    output req,
    input  rsp_valid,
    input  rsp
  );
endinterface

// file: core/smac_requester.sv
/*
  Requester end: registers user requests onto the link, returns answers.
  Assumes user inputs are on core_clk and already obey the pitch rules.
*/
`timescale 1ns/1ps
module smac_requester
(
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  smac_if.requester                link,
  input  wire logic                user_valid,
  input  wire smac_pkg::smac_req_s user_req,
  output logic                     user_rsp_valid,
  output smac_pkg::smac_rsp_s      user_rsp
);

  logic                 next_req_valid;
  smac_pkg::smac_req_s  next_req;
  logic                 next_rsp_valid;
  smac_pkg::smac_rsp_s  next_rsp;

  ////////////////////////////////////////////////////////////////////////////
  // Structured offsets are forced to whole doublewords before issue
  always_comb
  begin
    next_req_valid = user_valid;
    next_req       = user_req;
    if (user_req.surf == smac_pkg::SMAC_SURF_STRUCTURED)
    begin
      next_req.fmt    = smac_pkg::SMAC_FMT_RAW;
      next_req.u[1:0] = smac_pkg::DW_ALIGN;
    end
    next_rsp_valid = link.rsp_valid;
    next_rsp       = link.rsp;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.req_valid <= 1'b0;
      link.req       <= '0;
      user_rsp_valid <= 1'b0;
      user_rsp       <= '0;
    end
    else
    begin
      link.req_valid <= next_req_valid;
      link.req       <= next_req;
      user_rsp_valid <= next_rsp_valid;
      user_rsp       <= next_rsp;
    end
  end

endmodule

// file: core/smac_calc.sv
/*
  Surface address calculator: level sizes, level origins and byte addresses.
  Assumes requests arrive on core_clk from the requester end of smac_if.
*/
`timescale 1ns/1ps
module smac_calc
#(
  parameter int unsigned LAT = smac_pkg::PIPE_LAT
)
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  smac_if.calc      link
);

  localparam int unsigned XW = smac_pkg::DIM_W + 4;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [XW-1:0] lvl_size(input logic [smac_pkg::DIM_W-1:0] d,
                                             input logic [smac_pkg::LOD_W-1:0] l);
    logic [XW-1:0] s;
    s = XW'(d >> l);
    lvl_size = (s == '0) ? XW'(1) : s;
  endfunction

  function automatic logic [XW-1:0] pad_up(input logic [XW-1:0] v, input logic [3:0] a);
    logic [XW-1:0] m;
    m = XW'(a);
    pad_up = ((v + m - XW'(1)) / m) * m;
  endfunction

  function automatic logic [XW-1:0] half_up(input logic [XW-1:0] v);
    half_up = (v + XW'(1)) >> 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  smac_pkg::smac_req_s  r;
  logic [3:0]           ai;
  logic [3:0]           aj;
  logic                 compressed;
  logic [XW-1:0]        w_l;
  logic [XW-1:0]        h_l;
  logic [XW-1:0]        pw [0:15];
  logic [XW-1:0]        ph [0:15];
  logic [XW-1:0]        ux;
  logic [XW-1:0]        uy;
  logic [XW-1:0]        step_x;
  logic [XW-1:0]        ww;
  logic [XW-1:0]        hh;
  logic [63:0]          ofs;
  logic [63:0]          pitch_b;
  logic                 err;
  smac_pkg::smac_rsp_s  next_rsp;
  logic [LAT-1:0]       vld_pipe;
  smac_pkg::smac_rsp_s  rsp_pipe [0:LAT-1];
  logic [LAT-1:0]       next_vld_pipe;

  always_comb
  begin
    r          = link.req;
    compressed = (r.fmt == smac_pkg::SMAC_FMT_BC_SMALL) || (r.fmt == smac_pkg::SMAC_FMT_BC)
                 || (r.fmt == smac_pkg::SMAC_FMT_EIGHT_W);
    // Alignment unit by source and format
    ai = r.align_w;
    aj = r.align_h;
    if (r.surf == smac_pkg::SMAC_SURF_DEPTH)
    begin
      ai = (r.fmt == smac_pkg::SMAC_FMT_D16) ? 4'h8 : 4'h4;
      aj = 4'h4;
    end
    else if (r.surf == smac_pkg::SMAC_SURF_STENCIL)
    begin
      ai = 4'h8;
      aj = 4'h8;
    end
    else if (r.fmt == smac_pkg::SMAC_FMT_BC_SMALL || r.fmt == smac_pkg::SMAC_FMT_BC)
    begin
      ai = 4'h4;
      aj = 4'h4;
    end
    else if (r.fmt == smac_pkg::SMAC_FMT_EIGHT_W)
    begin
      ai = 4'h8;
      aj = 4'h4;
    end
    // Bump odd heights first, so a field of fifteen wraps to zero and falls back
    if (!compressed && aj[0])
      aj = aj + 4'h1;
    // Linear needs dword rows, tiled needs 16 byte rows; zero fields fall back
    if (ai == 4'h0)
      ai = 4'h4;
    if (aj == 4'h0)
      aj = r.tiled ? 4'h4 : 4'h2;
    // Padded sizes of every level, so any origin is a plain sum
    for (int l = 0; l < 16; l++)
    begin
      ww = lvl_size(r.width, smac_pkg::LOD_W'(l));
      hh = (r.surf == smac_pkg::SMAC_SURF_1D) ? XW'(1)
           : lvl_size(r.height, smac_pkg::LOD_W'(l));
      if (r.ms_depth_style && r.samples > 5'h1)
      begin
        ww = (r.samples >= 5'h8) ? half_up(ww) << 3 : half_up(ww) << 2;
        if (r.samples == 5'h10)
          hh = half_up(hh) << 3;
        else if (r.samples >= 5'h4)
          hh = half_up(hh) << 2;
      end
      pw[l] = pad_up(ww, ai);
      ph[l] = pad_up(hh, aj);
      if (r.surf == smac_pkg::SMAC_SURF_STENCIL)
      begin
        pw[l] = pw[l] << 1;
        ph[l] = ph[l] >> 1;
      end
    end
    w_l = pw[r.lod];
    h_l = ph[r.lod];
    // Upper-left origin of the requested level
    step_x = '0;
    for (int l = 0; l < 16; l++)
      if (l < int'(r.lod))
        step_x = step_x + pw[l];
    ux = '0;
    uy = '0;
    if (r.lod != '0)
    begin
      if (r.layout == smac_pkg::SMAC_MIP_STEP_RIGHT)
      begin
        ux = pw[0];
        for (int l = 1; l < 16; l++)
          if (l < int'(r.lod))
            uy = uy + ph[l];
      end
      else
      begin
        uy = ph[0];
        ux = (r.lod >= smac_pkg::LOD_W'(2)) ? pw[1] : '0;
        for (int l = 2; l < 16; l++)
          if (l < int'(r.lod))
            uy = uy + ph[l];
      end
    end
    // Byte offset from the base, which is the level zero upper left texel
    pitch_b = 64'(r.pitch_dw) << 2;
    err = 1'b0;
    unique case (r.surf)
      smac_pkg::SMAC_SURF_BUFFER, smac_pkg::SMAC_SURF_STRUCTURED:
      begin
        // Structures packed back to back, pitch is the stride
        ofs = 64'(r.slice) * pitch_b + 64'(r.u);
        err = (pitch_b > 64'(smac_pkg::MAX_STRUCT)) || r.tiled;
        if (r.surf == smac_pkg::SMAC_SURF_STRUCTURED)
          err = err || (64'(r.u) >= pitch_b);
      end
      smac_pkg::SMAC_SURF_1D:
      begin
        ux = step_x;
        uy = '0;
        ofs = (64'(r.slice) * 64'(r.slice_pitch) + 64'(step_x) + 64'(r.u))
              * 64'(r.bpp);
      end
      default:
      begin
        // Compressed rows hold four texel rows; the four-bit format takes half a byte per texel
        if (compressed)
          ofs = (64'(uy) * pitch_b >> 2) + 64'(ux) * 64'(r.bpp) * 64'h4;
        else if (r.fmt == smac_pkg::SMAC_FMT_FOUR_BIT)
          ofs = 64'(uy) * pitch_b + (64'(ux) >> 1);
        else if (r.fmt == smac_pkg::SMAC_FMT_YUV422)
          ofs = 64'(uy) * pitch_b + (64'(ux) << 1);
        else
          ofs = 64'(uy) * pitch_b + 64'(ux) * 64'(r.bpp);
        // Both half-byte compressed formats take two bytes per texel column
        if (r.fmt == smac_pkg::SMAC_FMT_BC_SMALL || r.fmt == smac_pkg::SMAC_FMT_EIGHT_W)
          ofs = (64'(uy) * pitch_b >> 2) + (64'(ux) << 1);
      end
    endcase
    err = err || (ofs >= 64'(smac_pkg::MAX_BYTES));
    next_rsp.lod_w = w_l;
    next_rsp.lod_h = h_l;
    next_rsp.ul_x  = ux;
    next_rsp.ul_y  = uy;
    next_rsp.addr  = err ? r.base : r.base + ofs[smac_pkg::ADDR_W-1:0];
    next_rsp.err   = err;
    next_vld_pipe  = {vld_pipe[LAT-2:0], link.req_valid};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline registers only retime; the math above is one combinational stage
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vld_pipe <= '0;
      for (int s = 0; s < LAT; s++)
        rsp_pipe[s] <= '0;
    end
    else
    begin
      vld_pipe    <= next_vld_pipe;
      rsp_pipe[0] <= next_rsp;
      for (int s = 1; s < LAT; s++)
        rsp_pipe[s] <= rsp_pipe[s-1];
    end
  end

  assign link.rsp_valid = vld_pipe[LAT-1];
  assign link.rsp       = rsp_pipe[LAT-1];

endmodule

// file: verif/smac_link_asserts.sv
/*
  Checker for the link between requester and calculator.
  Assumes it sits beside the smac_if instance, on core_clk, default latency.
*/
`timescale 1ns/1ps
module smac_link_asserts
(
  input wire logic                core_clk,
  input wire logic                rst_b,
  input wire logic                req_valid,
  input wire smac_pkg::smac_req_s req,
  input wire logic                rsp_valid,
  input wire smac_pkg::smac_rsp_s rsp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  chk_rsp_latency: assert property (req_valid |-> ##3 rsp_valid)
    else $error("answer not three cycles after request");
  chk_no_stray: assert property (rsp_valid |-> $past(req_valid, 3))
    else $error("answer without request");
  chk_min_size: assert property (req_valid && req.surf == smac_pkg::SMAC_SURF_2D
    |-> ##3 rsp.lod_w != '0 && rsp.lod_h != '0)
    else $error("level size below one");
  chk_err_base: assert property (rsp_valid && rsp.err |-> rsp.addr == $past(req.base, 3))
    else $error("refused answer not at base");
  chk_tiled_buf: assert property (req_valid && req.surf == smac_pkg::SMAC_SURF_BUFFER
    && req.tiled |-> ##3 rsp.err)
    else $error("tiled buffer accepted");
  chk_stride_cap: assert property (req_valid && req.surf == smac_pkg::SMAC_SURF_BUFFER
    && req.pitch_dw > 18'h200 |-> ##3 rsp.err)
    else $error("oversize structure accepted");
  chk_lod0_origin: assert property (req_valid && req.surf == smac_pkg::SMAC_SURF_2D
    && req.lod == '0 |-> ##3 rsp.ul_x == '0 && rsp.ul_y == '0)
    else $error("level zero not at origin");
  chk_even_row: assert property (req_valid && req.surf == smac_pkg::SMAC_SURF_2D
    && req.fmt == smac_pkg::SMAC_FMT_PLAIN |-> ##3 !rsp.ul_y[0])
    else $error("level on odd row");
  chk_flat_1d: assert property (req_valid && req.surf == smac_pkg::SMAC_SURF_1D
    |-> ##3 rsp.ul_y == '0)
    else $error("one dimensional level off row zero");
endmodule

// file: verif/surface_mip_address_calc_tb_top.sv
/*
  Bench joining requester and calculator; requests are streamed back to back.
  Assumes default calculator latency and a 100 MHz core clock.
*/
`timescale 1ns/1ps
module surface_mip_address_calc_tb_top;
  localparam logic [31:0] BASE = 32'h1000_0000;
  logic                core_clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                user_valid = 1'b0;
  smac_pkg::smac_req_s user_req = '0;
  logic                user_rsp_valid;
  smac_pkg::smac_rsp_s user_rsp;
  smac_pkg::smac_req_s r;
  smac_pkg::smac_rsp_s exp_q[$];
  logic                geo_q[$];
  int                  err_total = 0;
  int                  total_checks = 0;
  int                  cycles = 0;
  int                  i;
  int                  sm[4] = '{2, 4, 8, 16};
  int                  ws[4] = '{20, 20, 40, 40};
  int                  hs[4] = '{8, 12, 12, 24};
  int                  as[5] = '{4, 4, 5, 3, 3};
  int                  af[5] = '{1, 0, 0, 4, 3};
  int                  aw[5] = '{16, 12, 32, 16, 12};
  int                  ah[5] = '{8, 8, 4, 8, 8};
  int                  fc[5] = '{3, 2, 6, 5, 4};
  int                  fa[5] = '{'h900, 'h880, 'h2080, 'h2020, 'h880};

  always #5 core_clk = ~core_clk;

  smac_if link ();
  smac_requester u_smac_requester (.core_clk(core_clk), .rst_b(rst_b), .link(link),
    .user_valid(user_valid), .user_req(user_req), .user_rsp_valid(user_rsp_valid),
    .user_rsp(user_rsp));
  smac_calc u_smac_calc (.core_clk(core_clk), .rst_b(rst_b), .link(link));
  smac_link_asserts u_smac_link_asserts (.core_clk(core_clk), .rst_b(rst_b),
    .req_valid(link.req_valid), .req(link.req), .rsp_valid(link.rsp_valid), .rsp(link.rsp));
  ////////////////////////////////////////////////////////////
  function automatic smac_pkg::smac_req_s mk(int s, int f, int w, int h, int d);
    mk = '0;
    mk.surf = smac_pkg::smac_surf_e'(s[2:0]);
    mk.fmt = smac_pkg::smac_fmt_e'(f[2:0]);
    mk.samples = 5'h1;
    mk.bpp = 5'h4;
    mk.align_w = 4'h4;
    mk.align_h = 4'h4;
    mk.width = w[13:0];
    mk.height = h[13:0];
    mk.lod = d[3:0];
    mk.pitch_dw = 18'h80;
    mk.base = BASE;
  endfunction

  function automatic smac_pkg::smac_rsp_s ex(int lw, int lh, int x, int y, logic [31:0] a,
    logic e);
    ex.lod_w = lw[17:0];
    ex.lod_h = lh[17:0];
    ex.ul_x = x[17:0];
    ex.ul_y = y[17:0];
    ex.addr = a;
    ex.err = e;
  endfunction

  // Geometry is skipped where the answer only defines an address
  task automatic send(smac_pkg::smac_req_s q, smac_pkg::smac_rsp_s e, logic g);
    @(posedge core_clk);
    user_valid <= 1'b1;
    user_req <= q;
    exp_q.push_back(e);
    geo_q.push_back(g);
  endtask

  task automatic cmp(smac_pkg::smac_rsp_s g, smac_pkg::smac_rsp_s e, logic geo);
    total_checks++;
    if (g.addr !== e.addr || g.err !== e.err || (geo && g !== e))
    begin
      err_total++;
      $display("ERROR %0t: answer %h expected %h", $time, g, e);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (user_rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        err_total++;
        $display("ERROR %0t: answer without request", $time);
      end
      else
        cmp(user_rsp, exp_q.pop_front(), geo_q.pop_front());
    end
    if (cycles == 3000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      r = mk(3, 0, 64, 32, 2);
      r.layout = smac_pkg::smac_layout_e'(i[1:0]);
      send(r, ex(16, 8, i == 0 ? 64 : 32, i == 0 ? 16 : 32,
        BASE + (i == 0 ? 32'h2100 : 32'h4080), 1'b0), 1'b1);
    end
    send(mk(3, 0, 64, 32, 0), ex(64, 32, 0, 0, BASE, 1'b0), 1'b1);
    send(mk(3, 0, 64, 32, 3), ex(8, 4, 64, 24, BASE + 32'h3100, 1'b0), 1'b1);
    send(mk(3, 0, 64, 32, 7), ex(4, 4, 64, 40, BASE + 32'h5100, 1'b0), 1'b1);
    r = mk(3, 0, 64, 32, 3);
    r.layout = smac_pkg::SMAC_MIP_STEP_DOWN;
    send(r, ex(8, 4, 32, 40, BASE + 32'h5080, 1'b0), 1'b1);
    r = mk(3, 0, 10, 6, 0);
    r.align_w = 4'h0;
    r.align_h = 4'h0;
    send(r, ex(12, 6, 0, 0, BASE, 1'b0), 1'b1);
    r.tiled = 1'b1;
    send(r, ex(12, 8, 0, 0, BASE, 1'b0), 1'b1);
    r.tiled = 1'b0;
    r.align_h = 4'h3;
    send(r, ex(12, 8, 0, 0, BASE, 1'b0), 1'b1);
    for (i = 0; i < 4; i++)
    begin
      r = mk(3, 0, 10, 6, 0);
      r.ms_depth_style = 1'b1;
      r.samples = sm[i][4:0];
      send(r, ex(ws[i], hs[i], 0, 0, BASE, 1'b0), 1'b1);
    end
    for (i = 0; i < 5; i++)
      send(mk(as[i], af[i], 10, 6, 0), ex(aw[i], ah[i], 0, 0, BASE, 1'b0), 1'b1);
    for (i = 0; i < 5; i++)
    begin
      r = mk(3, fc[i], 64, 32, 2);
      r.bpp = 5'h1;
      send(r, ex(16, 8, 64, 16, BASE + fa[i], 1'b0), 1'b1);
    end
    r = mk(2, 0, 64, 1, 2);
    r.slice = 12'h2;
    r.slice_pitch = 22'hc8;
    r.u = 14'h3;
    send(r, ex(16, 4, 96, 0, BASE + 32'h7cc, 1'b0), 1'b1);
    r = mk(2, 0, 64, 1, 0);
    r.base = '0;
    r.bpp = 5'h1;
    r.slice = 12'h3ff;
    r.slice_pitch = 22'h20_0000;
    send(r, ex(64, 4, 0, 0, 32'h7fe0_0000, 1'b0), 1'b1);
    r.slice = 12'h400;
    send(r, ex(64, 4, 0, 0, 32'h0, 1'b1), 1'b1);
    r = mk(0, 0, 0, 0, 0);
    r.pitch_dw = 18'h10;
    r.slice = 12'h5;
    r.u = 14'h8;
    send(r, ex(0, 0, 0, 0, BASE + 32'h148, 1'b0), 1'b0);
    r.pitch_dw = 18'h200;
    send(r, ex(0, 0, 0, 0, BASE + 32'h2808, 1'b0), 1'b0);
    r.pitch_dw = 18'h201;
    send(r, ex(0, 0, 0, 0, BASE, 1'b1), 1'b0);
    r.pitch_dw = 18'h10;
    r.tiled = 1'b1;
    send(r, ex(0, 0, 0, 0, BASE, 1'b1), 1'b0);
    r = mk(1, 0, 0, 0, 0);
    r.pitch_dw = 18'h10;
    r.slice = 12'h3;
    r.u = 14'h6;
    send(r, ex(0, 0, 0, 0, BASE + 32'hc4, 1'b0), 1'b0);
    r.u = 14'h3c;
    send(r, ex(0, 0, 0, 0, BASE + 32'hfc, 1'b0), 1'b0);
    r.u = 14'h40;
    send(r, ex(0, 0, 0, 0, BASE, 1'b1), 1'b0);
    @(posedge core_clk);
    user_valid <= 1'b0;
    for (i = 0; i < 20 && exp_q.size() > 0; i++)
      @(posedge core_clk);
    if (exp_q.size() != 0)
    begin
      err_total++;
      $display("ERROR %0t: answers missing", $time);
    end
    complete_run();
  end
endmodule
